// ---- core/ocd_params.svh ----
`ifndef OCD_PARAMS_SVH
`define OCD_PARAMS_SVH

// Nominal oscillator band in kHz.
`define OCD_OSC_NOM_KHZ 8000
`define OCD_OSC_MIN_KHZ 4000
`define OCD_OSC_MAX_KHZ 10000

// Rate of ref_clk_in, which stands in for the oscillator, in kHz.
`define OCD_CLK_KHZ 25000

// Divider length and tap positions, as bit indices of the divider.
`define OCD_DIV_W 19
`define OCD_TAP_BIT0 3
`define OCD_TAP_BIT1 8
`define OCD_TAP_BIT2 13
`define OCD_TAP_BIT3 18
`define OCD_TAP_N 4
`define OCD_USER_TAP_N 2

// Start-up phases, as least times in microseconds.
`define OCD_POR_TIME_US 1000
`define OCD_CLR_TIME_US 4
`define OCD_POR_CYCLES ((`OCD_POR_TIME_US * `OCD_CLK_KHZ + 999) / 1000)
`define OCD_CLR_CYCLES ((`OCD_CLR_TIME_US * `OCD_CLK_KHZ + 999) / 1000)
`define OCD_TIMER_W 16

`endif

// ---- core/ocd_pkg.sv ----
`default_nettype none
`include "ocd_params.svh"

package ocd_pkg;

    typedef enum logic [2:0] {
        OCD_ST_POR,
        OCD_ST_CLEAR,
        OCD_ST_CONFIG,
        OCD_ST_USER,
        OCD_ST_OFF
    } ocd_phase_type;

    // Set by the user design: primitive present and which two taps it takes.
    typedef struct packed {
        logic osc_used;
        logic [1:0] sel_b;
        logic [1:0] sel_a;
    } ocd_user_cfg_type;

    typedef struct packed {
        logic [`OCD_USER_TAP_N-1:0] tap;
    } ocd_user_clk_type;

    typedef struct packed {
        ocd_phase_type phase;
        logic [`OCD_TIMER_W-1:0] timer;
        logic [`OCD_DIV_W-1:0] div;
        logic cfg_clk;
        logic osc_on;
        logic user_en;
    } ocd_state_type;

    typedef struct packed {
        logic q;
    } ocd_sync_state_type;

endpackage
`default_nettype wire

// ---- core/ocd_tap_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ocd_params.svh"

module ocd_tap_sync
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Divider taps and choice.
    input wire logic [`OCD_TAP_N-1:0] taps_in,
    input wire logic [1:0] sel_in,
    input wire logic en_in,
    // Resampled tap.
    output logic tap_out
);
    import ocd_pkg::*;

    ocd_sync_state_type st_q;
    ocd_sync_state_type st_d;

    // The chosen tap is resampled so the user sees one clean edge per change.
    always_comb
    begin
        st_d = st_q;
        st_d.q = en_in & taps_in[sel_in];
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign tap_out = st_q.q;

    a_sync_follows_tap: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $past(rst_b_in) |-> tap_out == ($past(en_in) & $past(taps_in[sel_in])))
        else $error("Resampled tap does not follow the selected tap.");

endmodule
`default_nettype wire

// ---- core/ocd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ocd_params.svh"

// Summary of operation
// - Oscillator times power-on delay, memory clearing, and drives master configuration clock.
// - Oscillator runs nominally near 8 MHz, anywhere between 4 and 10 MHz.
// - After configuration the undivided oscillator may be offered to user logic.
// - Built-in divider; any two of four taps selectable, each resynchronized.
// - Taps are divider bits three, eight, thirteen and eighteen.
// - Oscillator switches off after configuration when the primitive is absent.
module ocd_top
#(
    parameter int unsigned POR_CYCLES = `OCD_POR_CYCLES
)
(
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Configuration control.
    input wire logic master_mode_in,
    input wire logic cfg_done_in,
    input wire ocd_pkg::ocd_user_cfg_type user_cfg_in,
    // Start-up status.
    output logic osc_run_out,
    output logic cfg_clear_out,
    output logic configuration_clock_out,
    // User clocks.
    output logic osc_user_clk_out,
    output ocd_pkg::ocd_user_clk_type user_clk_out
);
    import ocd_pkg::*;

    localparam logic [`OCD_TIMER_W-1:0] POR_LOAD = `OCD_TIMER_W'(POR_CYCLES - 1);
    localparam logic [`OCD_TIMER_W-1:0] CLR_LOAD = `OCD_TIMER_W'(`OCD_CLR_CYCLES - 1);
    localparam int TAP_POS [`OCD_TAP_N] = '{`OCD_TAP_BIT0, `OCD_TAP_BIT1,
                                            `OCD_TAP_BIT2, `OCD_TAP_BIT3};
    // The oscillator rate must sit inside its band.
    localparam bit OSC_IN_BAND = (`OCD_OSC_NOM_KHZ >= `OCD_OSC_MIN_KHZ)
                                 && (`OCD_OSC_NOM_KHZ <= `OCD_OSC_MAX_KHZ);

    ocd_state_type st_q;
    ocd_state_type st_d;
    logic [`OCD_TAP_N-1:0] taps;
    logic [1:0] tap_sel [`OCD_USER_TAP_N];

    assign tap_sel[0] = user_cfg_in.sel_a;
    assign tap_sel[1] = user_cfg_in.sel_b;

    always_comb
    begin
        st_d = st_q;
        // The divider only stops when the oscillator itself is off.
        if (st_q.osc_on)
            st_d.div = st_q.div + `OCD_DIV_W'(1);
        case (st_q.phase)
            OCD_ST_POR:
            begin
                if (st_q.timer == '0)
                begin
                    st_d.phase = OCD_ST_CLEAR;
                    st_d.timer = CLR_LOAD;
                end
                else
                    st_d.timer = st_q.timer - `OCD_TIMER_W'(1);
            end
            OCD_ST_CLEAR:
            begin
                if (st_q.timer == '0)
                    st_d.phase = OCD_ST_CONFIG;
                else
                    st_d.timer = st_q.timer - `OCD_TIMER_W'(1);
            end
            OCD_ST_CONFIG:
            begin
                // Master modes take the configuration clock from the oscillator.
                st_d.cfg_clk = master_mode_in & ~st_q.cfg_clk;
                if (cfg_done_in)
                begin
                    st_d.cfg_clk = 1'b0;
                    if (user_cfg_in.osc_used)
                    begin
                        st_d.phase = OCD_ST_USER;
                        st_d.user_en = 1'b1;
                    end
                    else
                    begin
                        st_d.phase = OCD_ST_OFF;
                        st_d.osc_on = 1'b0;
                    end
                end
            end
            OCD_ST_USER:
            begin
                st_d.user_en = 1'b1;
            end
            OCD_ST_OFF:
            begin
                st_d.osc_on = 1'b0;
                st_d.user_en = 1'b0;
            end
            default:
            begin
                st_d.phase = OCD_ST_OFF;
                st_d.osc_on = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= '0;
            st_q.phase <= OCD_ST_POR;
            st_q.timer <= POR_LOAD;
            st_q.osc_on <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    // Taps are picked out of the divider at fixed bit positions.
    genvar gi;
    generate
        for (gi = 0; gi < `OCD_TAP_N; gi++)
        begin : g_tap
            assign taps[gi] = st_q.div[TAP_POS[gi]];
        end
        for (gi = 0; gi < `OCD_USER_TAP_N; gi++)
        begin : g_user
            ocd_tap_sync u_sync
            (
                .ref_clk_in(ref_clk_in),
                .rst_b_in(rst_b_in),
                .taps_in(taps),
                .sel_in(tap_sel[gi]),
                .en_in(st_q.user_en),
                .tap_out(user_clk_out.tap[gi])
            );
        end
    endgenerate

    assign osc_run_out = st_q.osc_on;
    assign cfg_clear_out = (st_q.phase == OCD_ST_CLEAR);
    assign configuration_clock_out = st_q.cfg_clk;
    // The enable only rises once, after configuration, so the gate is quiet until then.
    assign osc_user_clk_out = ref_clk_in & st_q.user_en;

    // Helper: length of the current phase.
    logic [`OCD_TIMER_W:0] phase_len_q;
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            phase_len_q <= '0;
        else if (st_d.phase != st_q.phase)
            phase_len_q <= '0;
        else
            phase_len_q <= phase_len_q + (`OCD_TIMER_W+1)'(1);
    end

    a_band_ok: assert property (@(posedge ref_clk_in) OSC_IN_BAND)
        else $error("Oscillator rate outside its band.");

    a_por_length: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (st_q.phase == OCD_ST_POR) && (st_d.phase == OCD_ST_CLEAR)
        |-> phase_len_q == (`OCD_TIMER_W+1)'(POR_CYCLES - 1))
        else $error("Power-on delay has the wrong length.");

    a_clear_length: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (st_q.phase == OCD_ST_CLEAR) && (st_d.phase == OCD_ST_CONFIG)
        |-> phase_len_q == (`OCD_TIMER_W+1)'(`OCD_CLR_CYCLES - 1))
        else $error("Memory clearing has the wrong length.");

    a_cfg_clk_master: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (st_q.phase == OCD_ST_CONFIG) && master_mode_in && !cfg_done_in
        |=> configuration_clock_out != $past(configuration_clock_out))
        else $error("Configuration clock not toggling in master mode.");

    a_cfg_clk_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (st_q.phase != OCD_ST_CONFIG) |-> !configuration_clock_out)
        else $error("Configuration clock active outside configuration.");

    a_off_unused: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (st_q.phase == OCD_ST_CONFIG) && cfg_done_in && !user_cfg_in.osc_used
        |=> !osc_run_out ##1 !osc_run_out && $stable(st_q.div))
        else $error("Oscillator not switched off when unused.");

    a_user_osc_on: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (st_q.phase == OCD_ST_CONFIG) && cfg_done_in && user_cfg_in.osc_used
        |=> st_q.user_en && osc_run_out)
        else $error("User clock not offered after configuration.");

    a_div_counts: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        osc_run_out |=> st_q.div == $past(st_q.div) + `OCD_DIV_W'(1))
        else $error("Divider not counting.");

    a_tap_period: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(taps[0]) |-> ##16 ($rose(taps[0]) || !osc_run_out))
        else $error("First tap is not divide by sixteen.");

    // Once granted, the user clock stays until the next reset.
    a_user_en_kept: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        st_q.user_en |=> st_q.user_en && osc_run_out)
        else $error("User clock withdrawn after configuration.");

    a_user_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !st_q.user_en ##1 !st_q.user_en |-> user_clk_out.tap == '0)
        else $error("User taps active before configuration.");

    c_to_user: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        st_q.phase == OCD_ST_USER);
    c_to_off: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        st_q.phase == OCD_ST_OFF);
    c_master_cfg: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        configuration_clock_out);
    c_tap_rise: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(user_clk_out.tap[1]));
    c_slave_done: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (st_q.phase == OCD_ST_CONFIG) && cfg_done_in && !master_mode_in);

endmodule
`default_nettype wire

// ---- bench/ocd_user_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module ocd_user_model
(
    // Oscillator clock as user logic sees it.
    input wire logic osc_user_clk_in,
    // Choices made by the user design.
    input wire logic place_in,
    input wire logic [1:0] sel_a_in,
    input wire logic [1:0] sel_b_in,
    // Settings seen by the device, and activity seen by the bench.
    output var ocd_pkg::ocd_user_cfg_type user_cfg_out,
    output logic [15:0] edge_cnt_out
);
    import ocd_pkg::*;

    always_comb
    begin
        user_cfg_out = '{osc_used: place_in, sel_b: sel_b_in, sel_a: sel_a_in};
    end

    // User logic clocked by the oscillator counts its own edges.
    initial edge_cnt_out = 16'h0000;
    always @(posedge osc_user_clk_in)
    begin
        edge_cnt_out <= edge_cnt_out + 16'h0001;
    end
endmodule

`default_nettype wire

// ---- bench/tb_onchip_osc_clock_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ocd_params.svh"

module tb_onchip_osc_clock_divider;
    import ocd_pkg::*;
    localparam int unsigned POR_N = 20;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic master_mode_in = 1'b0;
    logic cfg_done_in = 1'b0;
    logic place_in = 1'b0;
    logic [1:0] sel_a_in = 2'h0;
    logic [1:0] sel_b_in = 2'h0;
    ocd_user_cfg_type user_cfg;
    logic osc_run, cfg_clear, cfg_clk, osc_user_clk;
    ocd_user_clk_type user_clk;
    logic [15:0] edge_cnt;
    int miscompares = 0;
    int compares = 0;

    ocd_top #(.POR_CYCLES(POR_N)) uut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .master_mode_in(master_mode_in), .cfg_done_in(cfg_done_in), .user_cfg_in(user_cfg),
        .osc_run_out(osc_run), .cfg_clear_out(cfg_clear), .configuration_clock_out(cfg_clk),
        .osc_user_clk_out(osc_user_clk), .user_clk_out(user_clk));
    ocd_user_model partner (.osc_user_clk_in(osc_user_clk), .place_in(place_in),
        .sel_a_in(sel_a_in), .sel_b_in(sel_b_in), .user_cfg_out(user_cfg),
        .edge_cnt_out(edge_cnt));

    initial
    begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    task automatic close_out;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic give_up(input string msg);
        check(1'b0, msg);
        close_out();
    endtask

    // Resets, then walks the power-on delay and the clearing phase.
    task automatic start_up(input logic mst, input logic use_osc, input logic [1:0] a,
                            input logic [1:0] b);
        int n;
        @(negedge ref_clk_in);
        rst_b_in = 1'b0;
        master_mode_in = mst;
        place_in = use_osc;
        sel_a_in = a;
        sel_b_in = b;
        repeat (3) @(negedge ref_clk_in);
        check(osc_run === 1'b1 && cfg_clear === 1'b0 && user_clk.tap === 2'h0, "reset");
        rst_b_in = 1'b1;
        n = 0;
        while (cfg_clear !== 1'b1)
        begin
            @(negedge ref_clk_in);
            n++;
            if (n > POR_N + 10) give_up("no clearing phase");
        end
        check(n == POR_N, "power-on delay length");
        n = 0;
        while (cfg_clear === 1'b1)
        begin
            @(negedge ref_clk_in);
            n++;
            if (n > 2 * `OCD_CLR_CYCLES) give_up("clearing never ends");
        end
        check(n == `OCD_CLR_CYCLES, "clearing length");
        check(osc_run === 1'b1, "oscillator running in config");
        $display("test start_up done");
    endtask

    task automatic config_clock(input logic mst);
        logic prev;
        repeat (2) @(negedge ref_clk_in);
        // One rising edge lies between taking prev and the compare.
        repeat (8)
        begin
            prev = cfg_clk;
            @(posedge ref_clk_in);
            #5 check(osc_user_clk === 1'b0, "user clock before done");
            @(negedge ref_clk_in);
            check(mst ? (cfg_clk === ~prev) : (cfg_clk === 1'b0), "config clock");
        end
        $display("test config_clock done");
    endtask

    task automatic finish_config;
        @(negedge ref_clk_in);
        cfg_done_in = 1'b1;
        @(negedge ref_clk_in);
        cfg_done_in = 1'b0;
        check(cfg_clk === 1'b0, "config clock stops");
    endtask

    // Time between two changes of one tap must be half its period.
    task automatic tap_period(input int idx, input int half);
        int n;
        logic prev;
        for (int k = 0; k < 2; k++)
        begin
            prev = user_clk.tap[idx];
            n = 0;
            while (user_clk.tap[idx] === prev)
            begin
                @(negedge ref_clk_in);
                n++;
                if (n > 2 * half + 4) give_up("tap stuck");
            end
        end
        check(n == half, "tap period");
    endtask

    task automatic user_on(input int half0, input int half1);
        logic [15:0] c0;
        finish_config();
        @(posedge ref_clk_in);
        #5 check(osc_user_clk === 1'b1, "user clock live");
        @(negedge ref_clk_in);
        c0 = edge_cnt;
        repeat (50) @(negedge ref_clk_in);
        check(edge_cnt - c0 === 16'h0032, "user clock edges");
        tap_period(0, half0);
        if (half1 > 0) tap_period(1, half1);
        // The slowest tap cannot have risen this soon after reset.
        else check(user_clk.tap[1] === 1'b0, "slowest tap risen too early");
        $display("test user_on done");
    endtask

    task automatic osc_off;
        finish_config();
        @(negedge ref_clk_in);
        repeat (40)
        begin
            check(osc_run === 1'b0 && user_clk.tap === 2'h0, "oscillator off");
            @(posedge ref_clk_in);
            #5 check(osc_user_clk === 1'b0, "no user clock");
            @(negedge ref_clk_in);
        end
        $display("test osc_off done");
    endtask

    initial
    begin
        #(40 * 100000) give_up("run limit reached");
    end

    initial
    begin
        start_up(1'b1, 1'b1, 2'h0, 2'h1);
        config_clock(1'b1);
        user_on(1 << `OCD_TAP_BIT0, 1 << `OCD_TAP_BIT1);
        start_up(1'b1, 1'b1, 2'h2, 2'h3);
        user_on(1 << `OCD_TAP_BIT2, 0);
        start_up(1'b0, 1'b0, 2'h0, 2'h0);
        config_clock(1'b0);
        osc_off();
        close_out();
    end
endmodule

`default_nettype wire
